/* rtl/clock_gating_map.vh */
// Register map, field positions, reset values and timing for clock gating
`ifndef CLOCK_GATING_MAP_VH
`define CLOCK_GATING_MAP_VH

// Register indices; byte address is four times the index
`define REG_ENABLE_0_INDEX   16'h2780
`define REG_ENABLE_1_INDEX   16'h2781
`define REG_FORCE_0_INDEX    16'h2782
`define REG_FORCE_1_INDEX    16'h2783
`define REG_STATUS_INDEX     16'h2784

// Enable register 0 fields
`define EN0_MODEM_FSM        7
`define EN0_TRANSMIT         6
`define EN0_RECEIVE          5
`define EN0_DC_CANCEL        4
`define EN0_TEST             3
`define EN0_RX_FIFO          2
`define EN0_TX_FIFO          1
`define EN0_TX_AUTO_OFF      0

// Enable register 1 fields
`define EN1_CLOCK_OUT_EN     7
`define EN1_CLOCK_SEL_MSB    6
`define EN1_CLOCK_SEL_LSB    4
`define EN1_PHY_REGS         3
`define EN1_RF_REGS          2
`define EN1_MAC_REGS         1

// Force register 0 fields
`define FE0_VITERBI          7
`define FE0_TRANSMIT         6
`define FE0_RECEIVE          5
`define FE0_DC_CANCEL        4
`define FE0_TIMING_EST       3
`define FE0_GAIN_CONTROL     2
`define FE0_CORRELATOR       1

// Force register 1 fields
`define FE1_MODEM_FSM        5
`define FE1_RX_FIFO          4
`define FE1_TX_FIFO          3
`define FE1_PHY_REGS         2
`define FE1_RF_REGS          1
`define FE1_MAC_REGS         0

// Reset values and writable bits
`define EN0_RESET            8'hFE
`define EN1_RESET            8'h0E
`define FE0_RESET            8'h00
`define FE1_RESET            8'h00
`define EN0_MASK             8'hFF
`define EN1_MASK             8'hFE
`define FE0_MASK             8'hFE
`define FE1_MASK             8'h3F
`define GATE_RESET           14'h03FF

// Output clock selection
`define CLOCK_SEL_OFF        3'h7
`define PCLK_KHZ             50000
`define OUT_FREQ_0_KHZ       500
`define OUT_FREQ_1_KHZ       1000
`define OUT_FREQ_2_KHZ       2000
`define OUT_FREQ_3_KHZ       4000
`define OUT_FREQ_4_KHZ       8000
`define OUT_FREQ_5_KHZ       16000
`define OUT_FREQ_6_KHZ       32000

`endif

/* rtl/clock_output_divider.v */
// Glitch-free divider for the external clock output
`timescale 1ns/1ps
`default_nettype none
`include "clock_gating_map.vh"

module clock_output_divider #(
	parameter CNT_WIDTH = 16
) (
	// Clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// Control
	input  wire       run,
	input  wire [2:0] sel,
	// Output
	output reg        clock_out,
	output reg        running
);

	reg [CNT_WIDTH-1:0] count;
	reg [2:0]           active_sel;

	// Half period in pclk cycles, rounded down, at least one
	function [CNT_WIDTH-1:0] half_period;
		input [2:0] code;
		integer freq;
		integer cycles;
		begin
			case (code)
				3'h0:    freq = `OUT_FREQ_0_KHZ;
				3'h1:    freq = `OUT_FREQ_1_KHZ;
				3'h2:    freq = `OUT_FREQ_2_KHZ;
				3'h3:    freq = `OUT_FREQ_3_KHZ;
				3'h4:    freq = `OUT_FREQ_4_KHZ;
				3'h5:    freq = `OUT_FREQ_5_KHZ;
				default: freq = `OUT_FREQ_6_KHZ;
			endcase
			cycles = `PCLK_KHZ / (2 * freq);
			if (cycles < 1)
				cycles = 1;
			half_period = cycles[CNT_WIDTH-1:0];
		end
	endfunction

	wire phase_end = (count == half_period(active_sel) - 1'b1);

	// Phases always complete; new select taken only at a rising edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count      <= {CNT_WIDTH{1'b0}};
			active_sel <= 3'h0;
			clock_out  <= 1'b0;
			running    <= 1'b0;
		end else if (!running) begin
			count <= {CNT_WIDTH{1'b0}};
			if (run) begin
				running    <= 1'b1;
				active_sel <= sel;
				clock_out  <= 1'b1;
			end
		end else if (phase_end) begin
			count <= {CNT_WIDTH{1'b0}};
			if (clock_out) begin
				clock_out <= 1'b0;
			end else if (run) begin
				clock_out  <= 1'b1;
				active_sel <= sel;
			end else begin
				running <= 1'b0;
			end
		end else begin
			count <= count + 1'b1;
		end
	end

endmodule // clock_output_divider

`default_nettype wire

/* rtl/radio_clock_gating_control.v */
// Clock gating controller for the modem and MAC blocks, APB slave
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gating_map.vh"

// Function
// - Enable register 0 bits 7..4 gate fsm, transmit, receive, dc clocks; reset 1.
// - Enable register 0 bits 3..1 gate test, rx fifo, tx fifo clocks; reset 1.
// - Auto-off bit set: tx fifo clock stops on dma transfer done.
// - Enable register 1 bit 7 enables the clock output; reset 0.
// - Three-bit select picks 500 kHz to 25 MHz (codes 5 and 6 both give 25 MHz); code 7 is off.
// - Enable register 1 bits 3..1 gate phy, rf, mac register clocks.
// - A set force bit keeps its clock running whatever the enables say.
// - Force register 0 bits 7..4 force viterbi, transmit, receive, dc clocks.
// - Force register 0 bits 3..1 force timing, gain, correlator clocks.
// - Force register 1 bits 5..3 force fsm, rx fifo, tx fifo clocks.
// - Force register 1 bits 2..0 force phy, rf, mac register clocks.
// - Force register 1 keeps its contents through retention power-down.
module radio_clock_gating_control #(
	parameter ADDR_WIDTH = 16,
	parameter CNT_WIDTH  = 16
) (
	// Clock and resets
	input  wire                  pclk,
	input  wire                  presetn,
	input  wire                  retain_resetn,
	// APB slave
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [ADDR_WIDTH-1:0] paddr,
	input  wire [31:0]           pwdata,
	input  wire [3:0]            pstrb,
	output wire                  pready,
	output reg  [31:0]           prdata,
	output reg                   pslverr,
	// Block events and requests
	input  wire                  dma_tx_done,
	input  wire                  viterbi_clock_request,
	input  wire                  timing_estimator_clock_request,
	input  wire                  gain_control_clock_request,
	input  wire                  correlator_clock_request,
	// Gate enables
	output wire                  modem_fsm_clock_gate,
	output wire                  transmit_clock_gate,
	output wire                  receive_clock_gate,
	output wire                  dc_cancel_clock_gate,
	output wire                  test_clock_gate,
	output wire                  rx_fifo_clock_gate,
	output wire                  tx_fifo_clock_gate,
	output wire                  phy_regs_clock_gate,
	output wire                  rf_regs_clock_gate,
	output wire                  mac_regs_clock_gate,
	output wire                  viterbi_clock_gate,
	output wire                  timing_estimator_clock_gate,
	output wire                  gain_control_clock_gate,
	output wire                  correlator_clock_gate,
	// External clock output
	output wire                  clock_output,
	output wire                  clock_output_running
);

	localparam [2:0] SEL_ENABLE_0 = 3'h0;
	localparam [2:0] SEL_ENABLE_1 = 3'h1;
	localparam [2:0] SEL_FORCE_0  = 3'h2;
	localparam [2:0] SEL_FORCE_1  = 3'h3;
	localparam [2:0] SEL_STATUS   = 3'h4;
	localparam [2:0] SEL_NONE     = 3'h7;

	reg  [7:0]  modem_clock_enable_0;
	reg  [7:0]  modem_clock_enable_1;
	reg  [7:0]  modem_clock_force_0;
	reg  [7:0]  modem_clock_force_1;
	reg  [7:0]  next_enable_0;
	reg  [13:0] gate;
	reg  [13:0] next_gate;
	reg  [2:0]  setup_sel;
	wire [2:0]  access_sel;
	wire        setup_phase;
	wire        write_taken;
	wire        tx_auto_stop;
	wire [2:0]  clock_sel;
	wire        clock_run;

	// Fields of the enable registers
	wire        modem_fsm_clock_enable;
	wire        transmit_clock_enable;
	wire        receive_clock_enable;
	wire        dc_cancel_clock_enable;
	wire        test_clock_enable;
	wire        mac_rx_fifo_clock_enable;
	wire        mac_tx_fifo_clock_enable;
	wire        tx_fifo_clock_auto_off;
	wire        clock_output_enable;
	wire        phy_regs_clock_enable;
	wire        rf_regs_clock_enable;
	wire        mac_regs_clock_enable;
	// Fields of the force registers
	wire        viterbi_clock_force;
	wire        transmit_clock_force;
	wire        receive_clock_force;
	wire        dc_cancel_clock_force;
	wire        timing_estimator_clock_force;
	wire        gain_control_clock_force;
	wire        correlator_clock_force;
	wire        modem_fsm_clock_force;
	wire        rx_fifo_clock_force;
	wire        tx_fifo_clock_force;
	wire        phy_regs_clock_force;
	wire        rf_regs_clock_force;
	wire        mac_regs_clock_force;

	// Field taps
	assign modem_fsm_clock_enable = modem_clock_enable_0[`EN0_MODEM_FSM];
	assign transmit_clock_enable = modem_clock_enable_0[`EN0_TRANSMIT];
	assign receive_clock_enable = modem_clock_enable_0[`EN0_RECEIVE];
	assign dc_cancel_clock_enable = modem_clock_enable_0[`EN0_DC_CANCEL];
	assign test_clock_enable = modem_clock_enable_0[`EN0_TEST];
	assign mac_rx_fifo_clock_enable = modem_clock_enable_0[`EN0_RX_FIFO];
	assign mac_tx_fifo_clock_enable = modem_clock_enable_0[`EN0_TX_FIFO];
	assign tx_fifo_clock_auto_off = modem_clock_enable_0[`EN0_TX_AUTO_OFF];
	assign clock_output_enable = modem_clock_enable_1[`EN1_CLOCK_OUT_EN];
	assign phy_regs_clock_enable = modem_clock_enable_1[`EN1_PHY_REGS];
	assign rf_regs_clock_enable = modem_clock_enable_1[`EN1_RF_REGS];
	assign mac_regs_clock_enable = modem_clock_enable_1[`EN1_MAC_REGS];

	assign viterbi_clock_force = modem_clock_force_0[`FE0_VITERBI];
	assign transmit_clock_force = modem_clock_force_0[`FE0_TRANSMIT];
	assign receive_clock_force = modem_clock_force_0[`FE0_RECEIVE];
	assign dc_cancel_clock_force = modem_clock_force_0[`FE0_DC_CANCEL];
	assign timing_estimator_clock_force = modem_clock_force_0[`FE0_TIMING_EST];
	assign gain_control_clock_force = modem_clock_force_0[`FE0_GAIN_CONTROL];
	assign correlator_clock_force = modem_clock_force_0[`FE0_CORRELATOR];
	assign modem_fsm_clock_force = modem_clock_force_1[`FE1_MODEM_FSM];
	assign rx_fifo_clock_force = modem_clock_force_1[`FE1_RX_FIFO];
	assign tx_fifo_clock_force = modem_clock_force_1[`FE1_TX_FIFO];
	assign phy_regs_clock_force = modem_clock_force_1[`FE1_PHY_REGS];
	assign rf_regs_clock_force = modem_clock_force_1[`FE1_RF_REGS];
	assign mac_regs_clock_force = modem_clock_force_1[`FE1_MAC_REGS];

	// Map a byte address onto a register select
	function [2:0] decode;
		input [ADDR_WIDTH-1:0] addr;
		begin
			if (addr[1:0] != 2'b00)
				decode = SEL_NONE;
			else if (addr == (`REG_ENABLE_0_INDEX << 2))
				decode = SEL_ENABLE_0;
			else if (addr == (`REG_ENABLE_1_INDEX << 2))
				decode = SEL_ENABLE_1;
			else if (addr == (`REG_FORCE_0_INDEX << 2))
				decode = SEL_FORCE_0;
			else if (addr == (`REG_FORCE_1_INDEX << 2))
				decode = SEL_FORCE_1;
			else if (addr == (`REG_STATUS_INDEX << 2))
				decode = SEL_STATUS;
			else
				decode = SEL_NONE;
		end
	endfunction

	// Bus handshake, no wait states
	assign pready      = 1'b1;
	assign setup_phase = psel & ~penable;
	assign access_sel  = decode(paddr);
	assign write_taken = psel & penable & pwrite & pstrb[0];

	// Read data and error captured in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_sel <= SEL_NONE;
			prdata    <= 32'h00000000;
			pslverr   <= 1'b0;
		end else if (setup_phase) begin
			setup_sel <= access_sel;
			pslverr   <= (access_sel == SEL_NONE);
			case (access_sel)
				SEL_ENABLE_0: prdata <= {24'h000000, modem_clock_enable_0};
				SEL_ENABLE_1: prdata <= {24'h000000, modem_clock_enable_1};
				SEL_FORCE_0:  prdata <= {24'h000000, modem_clock_force_0};
				SEL_FORCE_1:  prdata <= {24'h000000, modem_clock_force_1};
				SEL_STATUS:   prdata <= {17'h00000, clock_output_running, gate};
				default:      prdata <= 32'h00000000;
			endcase
		end else if (!psel) begin
			pslverr <= 1'b0;
		end
	end

	// Auto-off stop of the tx fifo clock
	assign tx_auto_stop = tx_fifo_clock_auto_off & dma_tx_done;

	// Write to enable 0; the done event wins over a same-cycle write
	always @* begin
		next_enable_0 = modem_clock_enable_0;
		if (write_taken && setup_sel == SEL_ENABLE_0)
			next_enable_0 = pwdata[7:0] & `EN0_MASK;
		if (tx_auto_stop)
			next_enable_0[`EN0_TX_FIFO] = 1'b0;
	end

	// Enable registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_clock_enable_0 <= `EN0_RESET;
			modem_clock_enable_1 <= `EN1_RESET;
		end else begin
			modem_clock_enable_0 <= next_enable_0;
			if (write_taken && setup_sel == SEL_ENABLE_1)
				modem_clock_enable_1 <= pwdata[7:0] & `EN1_MASK;
		end
	end

	// Force register 0 on the system reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_clock_force_0 <= `FE0_RESET;
		end else if (write_taken && setup_sel == SEL_FORCE_0) begin
			modem_clock_force_0 <= pwdata[7:0] & `FE0_MASK;
		end
	end

	// Force register 1 survives the system reset
	always @(posedge pclk or negedge retain_resetn) begin
		if (!retain_resetn) begin
			modem_clock_force_1 <= `FE1_RESET;
		end else if (write_taken && setup_sel == SEL_FORCE_1) begin
			modem_clock_force_1 <= pwdata[7:0] & `FE1_MASK;
		end
	end

	// Gate enables: enable bit or request, or force bit; the test gate takes its enable bit only
	always @* begin
		next_gate[0]  = modem_fsm_clock_enable |
			modem_fsm_clock_force;
		next_gate[1]  = transmit_clock_enable |
			transmit_clock_force;
		next_gate[2]  = receive_clock_enable |
			receive_clock_force;
		next_gate[3]  = dc_cancel_clock_enable |
			dc_cancel_clock_force;
		next_gate[4]  = test_clock_enable;
		next_gate[5]  = mac_rx_fifo_clock_enable |
			rx_fifo_clock_force;
		next_gate[6]  = mac_tx_fifo_clock_enable |
			tx_fifo_clock_force;
		next_gate[7]  = phy_regs_clock_enable |
			phy_regs_clock_force;
		next_gate[8]  = rf_regs_clock_enable |
			rf_regs_clock_force;
		next_gate[9]  = mac_regs_clock_enable |
			mac_regs_clock_force;
		next_gate[10] = viterbi_clock_request |
			viterbi_clock_force;
		next_gate[11] = timing_estimator_clock_request |
			timing_estimator_clock_force;
		next_gate[12] = gain_control_clock_request |
			gain_control_clock_force;
		next_gate[13] = correlator_clock_request |
			correlator_clock_force;
	end

	// Registered gate enables change only on a pclk edge or at the presetn reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate <= `GATE_RESET;
		end else begin
			gate <= next_gate;
		end
	end

	assign modem_fsm_clock_gate        = gate[0];
	assign transmit_clock_gate         = gate[1];
	assign receive_clock_gate          = gate[2];
	assign dc_cancel_clock_gate        = gate[3];
	assign test_clock_gate             = gate[4];
	assign rx_fifo_clock_gate          = gate[5];
	assign tx_fifo_clock_gate          = gate[6];
	assign phy_regs_clock_gate         = gate[7];
	assign rf_regs_clock_gate          = gate[8];
	assign mac_regs_clock_gate         = gate[9];
	assign viterbi_clock_gate          = gate[10];
	assign timing_estimator_clock_gate = gate[11];
	assign gain_control_clock_gate     = gate[12];
	assign correlator_clock_gate       = gate[13];

	// External clock output control
	assign clock_sel = modem_clock_enable_1[`EN1_CLOCK_SEL_MSB:`EN1_CLOCK_SEL_LSB];
	assign clock_run = clock_output_enable &
		(clock_sel != `CLOCK_SEL_OFF);

	clock_output_divider #(
		.CNT_WIDTH (CNT_WIDTH)
	) u_divider (
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (clock_run),
		.sel       (clock_sel),
		.clock_out (clock_output),
		.running   (clock_output_running)
	);

endmodule // radio_clock_gating_control

`default_nettype wire

/* verif/radio_clock_gating_chk.sv */
// Port checker for the clock gating controller
`timescale 1ns/1ps
`default_nettype none
module radio_clock_gating_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	// Requests and gates
	input wire logic viterbi_clock_request,
	input wire logic correlator_clock_request,
	input wire logic modem_fsm_clock_gate,
	input wire logic viterbi_clock_gate,
	input wire logic correlator_clock_gate,
	// Clock output
	input wire logic clock_output,
	input wire logic clock_output_running
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic wr_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wr_q <= 1'b0;
		else
			wr_q <= psel && penable && pwrite;
	end
	chk_reset_gates: assert property ($rose(presetn) |-> modem_fsm_clock_gate
		&& !viterbi_clock_gate && !correlator_clock_gate)
		else $error("gate reset values wrong");
	chk_out_reset: assert property ($rose(presetn) |-> !clock_output_running)
		else $error("clock output active after reset");
	chk_viterbi_req: assert property (viterbi_clock_request |=> viterbi_clock_gate)
		else $error("viterbi gate ignores request");
	chk_corr_req: assert property (correlator_clock_request |=> correlator_clock_gate)
		else $error("correlator gate ignores request");
	chk_out_idle: assert property (!clock_output_running |-> !clock_output)
		else $error("clock output high while stopped");
	chk_out_start: assert property ($rose(clock_output_running) |-> clock_output)
		else $error("clock output start not high");
	chk_out_stop: assert property ($fell(clock_output_running) |->
		!clock_output && !$past(clock_output))
		else $error("clock output stop truncated a phase");
	chk_fsm_change: assert property ($changed(modem_fsm_clock_gate) |-> $past(wr_q))
		else $error("modem gate changed without a write");
endmodule // radio_clock_gating_chk
bind radio_clock_gating_control radio_clock_gating_chk u_chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .viterbi_clock_request, .correlator_clock_request,
	.modem_fsm_clock_gate, .viterbi_clock_gate, .correlator_clock_gate,
	.clock_output, .clock_output_running);
`default_nettype wire

/* verif/radio_clock_gating_control_tb_top.sv */
// Testbench for the clock gating controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
	num_checks++; \
	if ((a) !== (b)) begin \
		err_count++; \
		$display("Error %0t: got %h want %h", $time, a, b); \
	end \
end
module radio_clock_gating_control_tb_top;
	localparam logic [15:0] A0 = 16'h9E00, A1 = 16'h9E04, A2 = 16'h9E08;
	localparam logic [15:0] A3 = 16'h9E0C, A4 = 16'h9E10;
	logic        pclk = 1'b0, presetn = 1'b0, retain_resetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, r;
	logic [3:0]  pstrb = 4'hF, req = 4'h0;
	logic        dma_tx_done = 1'b0, e;
	wire         pready, pslverr, clock_output, clock_output_running;
	wire  [31:0] prdata;
	wire  [13:0] g;
	int          err_count = 0, num_checks = 0, k, n, m;
	logic [15:0] ad [4] = '{A0, A1, A2, A3};
	logic [7:0]  mk [4] = '{8'hFF, 8'hFE, 8'hFE, 8'h3F};
	int          fb [13] = '{7, 6, 5, 4, 3, 2, 1, 5, 4, 3, 2, 1, 0};
	int          fi [13] = '{10, 1, 2, 3, 11, 12, 13, 0, 5, 6, 7, 8, 9};
	int          hp [7] = '{50, 25, 12, 6, 3, 1, 1};
	radio_clock_gating_control dut (
		.pclk(pclk), .presetn(presetn), .retain_resetn(retain_resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .dma_tx_done(dma_tx_done),
		.viterbi_clock_request(req[0]),
		.timing_estimator_clock_request(req[1]),
		.gain_control_clock_request(req[2]),
		.correlator_clock_request(req[3]),
		.modem_fsm_clock_gate(g[0]), .transmit_clock_gate(g[1]),
		.receive_clock_gate(g[2]), .dc_cancel_clock_gate(g[3]),
		.test_clock_gate(g[4]), .rx_fifo_clock_gate(g[5]),
		.tx_fifo_clock_gate(g[6]), .phy_regs_clock_gate(g[7]),
		.rf_regs_clock_gate(g[8]), .mac_regs_clock_gate(g[9]),
		.viterbi_clock_gate(g[10]), .timing_estimator_clock_gate(g[11]),
		.gain_control_clock_gate(g[12]), .correlator_clock_gate(g[13]),
		.clock_output(clock_output),
		.clock_output_running(clock_output_running)
	);
	always #10 pclk = ~pclk;
	// Bus transfer, entered just after a rising edge
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			err_count++;
			$display("Error %0t: bus wait timed out", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task rdc(input logic [15:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(r, x)
	endtask
	task gchk(input logic [13:0] x);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		`CHK(g, x)
		@(posedge pclk);
	endtask
	task pulse;
		dma_tx_done <= 1'b1;
		@(posedge pclk);
		dma_tx_done <= 1'b0;
	endtask
	task t_reset;
		rdc(A0, 32'hFE);
		rdc(A1, 32'h0E);
		rdc(A2, 32'h00);
		rdc(A3, 32'h00);
		gchk(14'h03FF);
	endtask
	task t_regs;
		for (int i = 0; i < 4; i++) begin
			wr(ad[i], 8'hFF);
			rdc(ad[i], {24'h0, mk[i]});
		end
		rdc(A4, 32'h3FFF);
		apb(1'b0, 16'h9E14, 32'h0);
		`CHK({e, r}, 33'h1_0000_0000)
		apb(1'b1, 16'h9E01, 32'h0);
		`CHK(e, 1'b1)
		pstrb <= 4'hE;
		wr(A0, 8'h00);
		pstrb <= 4'hF;
		rdc(A0, 32'hFF);
		for (int i = 0; i < 4; i++)
			wr(ad[i], 8'h00);
		gchk(14'h0000);
	endtask
	task t_enables;
		for (int b = 7; b > 0; b--) begin
			wr(A0, 8'h01 << b);
			gchk(14'h0001 << (7 - b));
		end
		wr(A0, 8'h00);
		for (int b = 3; b > 0; b--) begin
			wr(A1, 8'h01 << b);
			gchk(14'h0001 << (10 - b));
		end
		wr(A1, 8'h00);
	endtask
	task t_force;
		for (int i = 0; i < 13; i++) begin
			wr(i < 7 ? A2 : A3, 8'h01 << fb[i]);
			gchk(14'h0001 << fi[i]);
			wr(i < 7 ? A2 : A3, 8'h00);
		end
		req <= 4'hF;
		gchk(14'h3C00);
		req <= 4'h0;
	endtask
	task t_auto;
		wr(A0, 8'h03);
		pulse;
		gchk(14'h0000);
		rdc(A0, 32'h01);
		wr(A0, 8'h02);
		pulse;
		gchk(14'h0040);
		wr(A0, 8'h03);
		wr(A3, 8'h08);
		pulse;
		gchk(14'h0040);
		wr(A3, 8'h00);
	endtask
	task t_retain;
		wr(A3, 8'h2A);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(A3, 32'h2A);
		rdc(A0, 32'hFE);
		retain_resetn <= 1'b0;
		@(posedge pclk);
		retain_resetn <= 1'b1;
		@(posedge pclk);
		rdc(A3, 32'h00);
	endtask
	task t_clkout;
		for (int c = 0; c < 7; c++) begin
			wr(A1, {1'b1, c[2:0], 4'hE});
			k = 0;
			n = 0;
			m = 0;
			@(negedge pclk);
			while (clock_output !== 1'b1 && k < 300) begin
				@(negedge pclk);
				k++;
			end
			while (clock_output === 1'b1 && n < 300) begin
				@(negedge pclk);
				n++;
			end
			while (clock_output === 1'b0 && m < 300) begin
				@(negedge pclk);
				m++;
			end
			`CHK(n, hp[c])
			`CHK(m, hp[c])
			@(posedge pclk);
			wr(A1, 8'h0E);
			repeat (120) @(posedge pclk);
			`CHK({clock_output_running, clock_output}, 2'b00)
		end
		wr(A1, 8'hFE);
		repeat (120) @(posedge pclk);
		`CHK({clock_output_running, clock_output}, 2'b00)
	endtask
	task results;
		$display("Checks: %0d, errors: %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		results;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		retain_resetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_regs;
		t_enables;
		t_force;
		t_auto;
		t_retain;
		t_clkout;
		results;
	end
endmodule // radio_clock_gating_control_tb_top
`default_nettype wire
